//--- src/dtm_core.sv
/*
 * dual trace memory controller: acquisition into A, store, clear,
 * difference, max hold, markers, display read-out and AXI4-Lite slave.
 * assumes samples and display reads are synchronous to clk.
 */
`timescale 1ns/1ps
module dtm_core import dtm_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // sweep sample input
    input wire logic smpValid,
    output logic smpReady,
    input wire logic [DTM_AW-1:0] smpPoint,
    input wire logic [DTM_DW-1:0] smpData,
    input wire logic sweepRun,
    input wire logic singleSweep,
    // sweep control outputs
    output logic sweepRearm,
    output logic sweepStop,
    // display refresh port
    input wire logic dispReq,
    input wire logic [DTM_AW-1:0] dispPoint,
    output logic dispValid,
    input wire logic dispReady,
    output logic [DTM_DW-1:0] dispA,
    output logic [DTM_DW-1:0] dispB,
    output logic dispShowA,
    output logic dispShowB,
    output logic dispDiffMid,
    output logic dispSweepMark,
    output logic dispOffsMark,
    output logic dispTuneMark,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // trace memories
    logic [DTM_DW-1:0] memA [DTM_POINTS];
    logic [DTM_DW-1:0] memB [DTM_POINTS];

    typedef struct packed {
        dtm_op_e op;
        logic [DTM_AW-1:0] opPt;
        logic [7:0] ctrl;
        logic [DTM_AW-1:0] offPt;
        logic [DTM_AW-1:0] manPt;
        logic [DTM_AW-1:0] rdAddr;
        logic [DTM_AW-1:0] sweepPt;
        logic rearm;
        logic stop;
        logic awHave;
        logic [7:0] awAddr;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [1:0] bufCnt;
        logic [DTM_AW-1:0] bufPt0;
        logic [DTM_AW-1:0] bufPt1;
        logic dispOut;
        logic smpRdy;
        logic awRdy;
        logic wRdy;
        logic arRdy;
    } dtm_state_s;

    dtm_state_s st_q, st_d;

    // two-entry display buffer data
    logic [2*DTM_DW-1:0] bufData [2];
    logic [2*DTM_DW-1:0] bufIn;
    logic [DTM_DW-1:0] rdA, rdB;

    // combinational helpers
    logic busy, wrGo, accept, doWrite, memWrA, memWrB, pushBuf, popBuf;
    logic [DTM_AW-1:0] memAddrA;
    logic [DTM_DW-1:0] memDatA;
    logic [DTM_DW:0] diffWide;
    logic [31:0] rdWord;
    logic [1:0] rdResp;

    assign busy = st_q.op != DTM_IDLE;
    // stall acquisition while a whole-trace operation runs; the ready flop
    // mirrors op, so it drops on the same edge the walk starts
    assign smpReady = st_q.smpRdy;
    assign accept = smpValid & ~busy & sweepRun & (smpPoint <= DTM_LAST_PT);
    assign rdA = memA[st_q.opPt];
    assign diffWide = {1'b0, rdA} - {1'b0, memB[st_q.opPt]};
    assign wrGo = st_q.awHave & st_q.wHave & ~st_q.bValid;

    // write port of memory A: clear, difference or acquisition
    always_comb begin
        memWrA = 1'b0;
        memAddrA = smpPoint;
        memDatA = smpData;
        unique case (st_q.op)
            DTM_CLEAR: begin
                memWrA = 1'b1;
                memAddrA = st_q.opPt;
                memDatA = '0;
            end
            DTM_DIFF: begin
                memWrA = 1'b1;
                memAddrA = st_q.opPt;
                memDatA = diffWide[DTM_DW] ? '0 : diffWide[DTM_DW-1:0];
            end
            DTM_STORE: begin
                memWrA = 1'b0;
            end
            DTM_IDLE: begin
                // max hold keeps the larger value
                memWrA = accept & (~st_q.ctrl[DTM_CTRL_MAXH] | (smpData > memA[smpPoint]));
            end
        endcase
    end
    assign memWrB = st_q.op == DTM_STORE;

    // memories; no reset on the arrays, so contents stay unknown
    // after power-up until a clear command has walked memory A and a store has copied it into B
    always_ff @(posedge clk) begin
        if (memWrA) begin
            memA[memAddrA] <= memDatA;
        end
        if (memWrB) begin
            memB[st_q.opPt] <= rdA;
        end
    end

    // display buffer payload
    assign pushBuf = dispReq & (st_q.bufCnt != 2'd2);
    assign popBuf = dispValid & dispReady;
    assign rdB = memB[dispPoint];
    assign bufIn = {memA[dispPoint], rdB};
    always_ff @(posedge clk) begin
        if (pushBuf) begin
            bufData[st_q.bufCnt == 2'd0 || (st_q.bufCnt == 2'd1 && popBuf) ? 0 : 1] <= bufIn;
        end
        if (popBuf && st_q.bufCnt == 2'd2) begin
            bufData[0] <= bufData[1];
        end
    end

    // register read mux
    always_comb begin
        rdWord = 32'h0;
        rdResp = DTM_RESP_OKAY;
        unique case (s_axi_araddr)
            DTM_REG_CTRL: rdWord = {24'h0, st_q.ctrl};
            DTM_REG_CMD: rdWord = 32'h0;
            DTM_REG_STAT: rdWord = {20'h0, st_q.sweepPt, busy, st_q.op == DTM_STORE};
            DTM_REG_OFFPT: rdWord = {22'h0, st_q.offPt};
            DTM_REG_MANPT: rdWord = {22'h0, st_q.manPt};
            DTM_REG_RDADDR: rdWord = {22'h0, st_q.rdAddr};
            DTM_REG_RDDATA: rdWord = {12'h0, memA[st_q.rdAddr], memB[st_q.rdAddr]};
            default: rdResp = DTM_RESP_SLVERR;
        endcase
    end

    // next state
    always_comb begin
        st_d = st_q;
        st_d.rearm = 1'b0;
        st_d.stop = 1'b0;
        doWrite = wrGo;
        // axi write channels, address and data in either order
        if (s_axi_awvalid && !st_q.awHave) begin
            st_d.awHave = 1'b1;
            st_d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.wHave) begin
            st_d.wHave = 1'b1;
            st_d.wData = s_axi_wdata;
            st_d.wStrb = s_axi_wstrb;
        end
        if (st_q.bValid && s_axi_bready) begin
            st_d.bValid = 1'b0;
        end
        // a command write during a trace operation is refused with slverr
        if (doWrite) begin
            st_d.awHave = 1'b0;
            st_d.wHave = 1'b0;
            st_d.bValid = 1'b1;
            st_d.bResp = DTM_RESP_OKAY;
            unique case (st_q.awAddr)
                DTM_REG_CTRL: begin
                    if (st_q.wStrb[0]) st_d.ctrl = st_q.wData[7:0];
                end
                DTM_REG_CMD: begin
                    if (busy) begin
                        st_d.bResp = DTM_RESP_SLVERR;
                    end else if (st_q.wStrb[0]) begin
                        if (st_q.wData[DTM_CMD_TGLB]) st_d.ctrl[DTM_CTRL_SHOWB] = ~st_q.ctrl[DTM_CTRL_SHOWB];
                        if (st_q.wData[DTM_CMD_TGLM]) st_d.ctrl[DTM_CTRL_MAXH] = ~st_q.ctrl[DTM_CTRL_MAXH];
                        if (st_q.wData[DTM_CMD_TGLD]) begin
                            st_d.ctrl[DTM_CTRL_DIFF] = ~st_q.ctrl[DTM_CTRL_DIFF];
                            if (!st_q.ctrl[DTM_CTRL_DIFF]) st_d.op = DTM_DIFF;
                        end
                        if (st_q.wData[DTM_CMD_STORE]) begin
                            st_d.op = DTM_STORE;
                            st_d.ctrl[DTM_CTRL_SHOWB] = 1'b1;
                        end
                        if (st_q.wData[DTM_CMD_CLEAR]) begin
                            st_d.op = DTM_CLEAR;
                            st_d.rearm = st_q.ctrl[DTM_CTRL_CONT];
                            st_d.stop = singleSweep;
                        end
                        st_d.opPt = '0;
                    end
                end
                DTM_REG_OFFPT: begin
                    if (st_q.wStrb[0]) st_d.offPt[7:0] = st_q.wData[7:0];
                    if (st_q.wStrb[1]) st_d.offPt[9:8] = st_q.wData[9:8];
                end
                DTM_REG_MANPT: begin
                    if (st_q.wStrb[0]) st_d.manPt[7:0] = st_q.wData[7:0];
                    if (st_q.wStrb[1]) st_d.manPt[9:8] = st_q.wData[9:8];
                end
                DTM_REG_RDADDR: begin
                    if (st_q.wStrb[0]) st_d.rdAddr[7:0] = st_q.wData[7:0];
                    if (st_q.wStrb[1]) st_d.rdAddr[9:8] = st_q.wData[9:8];
                end
                DTM_REG_STAT, DTM_REG_RDDATA: begin
                    st_d.bResp = DTM_RESP_OKAY;
                end
                default: st_d.bResp = DTM_RESP_SLVERR;
            endcase
        end
        // axi read
        if (st_q.rValid && s_axi_rready) begin
            st_d.rValid = 1'b0;
        end
        if (s_axi_arvalid && !st_q.rValid) begin
            st_d.rValid = 1'b1;
            st_d.rData = rdWord;
            st_d.rResp = rdResp;
        end
        // whole-trace walk over points 0..1000
        if (busy) begin
            if (st_q.opPt == DTM_LAST_PT) begin
                st_d.op = DTM_IDLE;
                st_d.opPt = '0;
            end else begin
                st_d.opPt = st_q.opPt + 10'h1;
            end
        end
        // sweep position follows accepted samples
        if (accept) begin
            st_d.sweepPt = smpPoint;
        end
        // display buffer count
        unique case ({pushBuf, popBuf && st_q.bufCnt != 2'd0})
            2'b10: st_d.bufCnt = st_q.bufCnt + 2'd1;
            2'b01: st_d.bufCnt = st_q.bufCnt - 2'd1;
            default: st_d.bufCnt = st_q.bufCnt;
        endcase
        if (pushBuf) begin
            if (st_q.bufCnt == 2'd0 || (st_q.bufCnt == 2'd1 && popBuf)) st_d.bufPt0 = dispPoint;
            else st_d.bufPt1 = dispPoint;
        end
        if (popBuf && st_q.bufCnt == 2'd2) begin
            st_d.bufPt0 = st_q.bufPt1;
        end
        st_d.dispOut = st_d.bufCnt != 2'd0;
        // handshake levels for the next cycle, kept in flops so no port
        // is driven through logic
        st_d.smpRdy = st_d.op == DTM_IDLE;
        st_d.awRdy = ~st_d.awHave;
        st_d.wRdy = ~st_d.wHave;
        st_d.arRdy = ~st_d.rValid;
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
            st_q.op <= DTM_IDLE;
            st_q.ctrl <= DTM_CTRL_RST;
            // ready high during reset: requests may start at the first edge
            st_q.smpRdy <= 1'b1;
            st_q.awRdy <= 1'b1;
            st_q.wRdy <= 1'b1;
            st_q.arRdy <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // marker and flag outputs registered
    logic sweepMark_q, offsMark_q, tuneMark_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sweepMark_q <= 1'b0;
            offsMark_q <= 1'b0;
            tuneMark_q <= 1'b0;
        end else begin
            sweepMark_q <= sweepRun & st_q.ctrl[DTM_CTRL_SLOW] & (st_d.bufPt0 == st_d.sweepPt);
            offsMark_q <= st_q.ctrl[DTM_CTRL_OFFS] & (st_d.bufPt0 == st_d.offPt);
            tuneMark_q <= st_q.ctrl[DTM_CTRL_MAN] & (st_d.bufPt0 == st_d.manPt);
        end
    end

    // outputs
    assign dispValid = st_q.dispOut;
    assign dispA = bufData[0][2*DTM_DW-1:DTM_DW];
    assign dispB = bufData[0][DTM_DW-1:0];
    assign dispShowA = st_q.ctrl[DTM_CTRL_SHOWA];
    assign dispShowB = st_q.ctrl[DTM_CTRL_SHOWB];
    assign dispDiffMid = st_q.ctrl[DTM_CTRL_DIFF];
    assign dispSweepMark = sweepMark_q;
    assign dispOffsMark = offsMark_q;
    assign dispTuneMark = tuneMark_q;
    assign sweepRearm = st_q.rearm;
    assign sweepStop = st_q.stop;
    assign s_axi_awready = st_q.awRdy;
    assign s_axi_wready = st_q.wRdy;
    assign s_axi_bvalid = st_q.bValid;
    assign s_axi_bresp = st_q.bResp;
    assign s_axi_arready = st_q.arRdy;
    assign s_axi_rvalid = st_q.rValid;
    assign s_axi_rdata = st_q.rData;
    assign s_axi_rresp = st_q.rResp;

endmodule // dtm_core

//--- src/dtm_pkg.sv
/*
 * constants and types for the dual trace memory controller.
 * assumes one 50 MHz clock and an AXI4-Lite master for software access.
 */
// Operation
// - two trace memories of 1001 points
// - sweep samples written into A at position
// - acquisition updates only A, never B
// - clear erases A, rearms continuous, stops single
// - store copies A to B, shows B
// - B held until next store
// - B display toggle changes no data
// - difference toggle writes A minus B into A
// - difference zero placed at mid range; code clamps A minus B at 0 and only sets dispDiffMid
// - max hold writes only larger samples
// - sweep marker when sweep time one second plus
// - offset marker at reference point
// - manual mode marker follows manual point
// - points are 10-bit unsigned words
package dtm_pkg;
    localparam int DTM_POINTS = 1001;
    localparam int DTM_AW = 10;
    localparam int DTM_DW = 10;
    localparam logic [DTM_AW-1:0] DTM_LAST_PT = 10'h3e8;
    localparam logic [DTM_DW-1:0] DTM_MAX_AMP = 10'h3ff;
    localparam logic [DTM_DW-1:0] DTM_MID_AMP = 10'h200;
    // register byte offsets
    localparam logic [7:0] DTM_REG_CTRL = 8'h00;
    localparam logic [7:0] DTM_REG_CMD = 8'h04;
    localparam logic [7:0] DTM_REG_STAT = 8'h08;
    localparam logic [7:0] DTM_REG_OFFPT = 8'h0c;
    localparam logic [7:0] DTM_REG_MANPT = 8'h10;
    localparam logic [7:0] DTM_REG_RDADDR = 8'h14;
    localparam logic [7:0] DTM_REG_RDDATA = 8'h18;
    // ctrl bit positions
    localparam int DTM_CTRL_SHOWA = 0;
    localparam int DTM_CTRL_SHOWB = 1;
    localparam int DTM_CTRL_DIFF = 2;
    localparam int DTM_CTRL_MAXH = 3;
    localparam int DTM_CTRL_OFFS = 4;
    localparam int DTM_CTRL_MAN = 5;
    localparam int DTM_CTRL_SLOW = 6;
    localparam int DTM_CTRL_CONT = 7;
    // cmd bit positions (write one to act)
    localparam int DTM_CMD_CLEAR = 0;
    localparam int DTM_CMD_STORE = 1;
    localparam int DTM_CMD_TGLB = 2;
    localparam int DTM_CMD_TGLD = 3;
    localparam int DTM_CMD_TGLM = 4;
    localparam logic [7:0] DTM_CTRL_RST = 8'h81;
    localparam logic [1:0] DTM_RESP_OKAY = 2'h0;
    localparam logic [1:0] DTM_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        DTM_IDLE = 2'b00,
        DTM_CLEAR = 2'b01,
        DTM_STORE = 2'b10,
        DTM_DIFF = 2'b11
    } dtm_op_e;
endpackage

//--- verification/dtm_core_props.sv
/*
 * port timing checks for dtm_core.
 * assumes binding onto dtm_core, one clock, active low reset.
 */
`timescale 1ns/1ps
module dtm_core_props import dtm_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // axi4-lite
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // display and sweep
    input wire logic dispValid,
    input wire logic dispReady,
    input wire logic [DTM_DW-1:0] dispA,
    input wire logic sweepRearm,
    input wire logic sweepStop
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // address beyond the map taken
    sequence s_bad_aw;
        s_axi_awvalid && s_axi_awready && s_axi_awaddr > 8'h18;
    endsequence
    sequence s_err_b;
        s_axi_bvalid && s_axi_bresp == DTM_RESP_SLVERR;
    endsequence
    a_bad_write: assert property (s_bad_aw |-> ##[1:8] s_err_b)
        else $error("unmapped write not refused");
    a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18 |=>
        s_axi_rvalid && s_axi_rresp == DTM_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_disp_stands: assert property (dispValid && !dispReady |=> dispValid && $stable(dispA))
        else $error("display word lost under stall");
    a_rearm_pulse: assert property ($rose(sweepRearm) |=> !sweepRearm)
        else $error("rearm not a single pulse");
    a_stop_pulse: assert property ($rose(sweepStop) |=> !sweepStop)
        else $error("stop not a single pulse");
endmodule // dtm_core_props

bind dtm_core dtm_core_props u_props (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dispValid, .dispReady, .dispA,
    .sweepRearm, .sweepStop);

//--- verification/dtm_disp_model.sv
/*
 * display refresh model: requests one point, stalls three cycles in four.
 * assumes the bench picks the point and reads the last word taken.
 */
`timescale 1ns/1ps
module dtm_disp_model import dtm_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // point chosen by the bench
    input wire logic [DTM_AW-1:0] pt,
    // display port
    output logic dispReq,
    output logic [DTM_AW-1:0] dispPoint,
    input wire logic dispValid,
    output logic dispReady,
    input wire logic [DTM_DW-1:0] dispA,
    input wire logic [DTM_DW-1:0] dispB,
    input wire logic [2:0] marks,
    // last word taken
    output logic [DTM_DW-1:0] gotA,
    output logic [DTM_DW-1:0] gotB,
    output logic [2:0] gotMk
);
    logic [1:0] cnt;
    // push every cycle, drain slowly so the buffer fills
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dispReq <= 1'b0;
            dispPoint <= '0;
            dispReady <= 1'b0;
            cnt <= 2'h0;
        end else begin
            dispReq <= 1'b1;
            dispPoint <= pt;
            cnt <= cnt + 2'h1;
            dispReady <= (cnt == 2'h3);
            if (dispValid && dispReady) begin
                gotA <= dispA;
                gotB <= dispB;
                gotMk <= marks;
            end
        end
    end
endmodule // dtm_disp_model

//--- verification/tb.sv
/*
 * bench for dtm_core: axi4-lite tasks, sample feed, display model.
 * assumes a 50 MHz clock and the package register map.
 */
`timescale 1ns/1ps
module tb import dtm_pkg::*;;
    logic clk, nrst, smpValid, smpReady, sweepRun, singleSweep, sweepRearm, sweepStop;
    logic dispReq, dispValid, dispReady, dispShowA, dispShowB, dispDiffMid, sMk, oMk, tMk;
    logic [DTM_AW-1:0] smpPoint, pt, dispPoint;
    logic [DTM_DW-1:0] smpData, dispA, dispB, gotA, gotB;
    logic [2:0] gotMk;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, v;
    logic [1:0] bresp, rresp, r;
    int num_errors, check_count, rearmCnt, stopCnt, i;
    logic [9:0] tp [3] = '{10'h12c, 10'h1f4, 10'h2bc};
    logic [2:0] mk [3] = '{3'b001, 3'b010, 3'b100};
    logic [19:0] ab [3] = '{20'h0, 20'h00300, 20'haa800};
    dtm_core DUT (.clk(clk), .nrst(nrst), .smpValid(smpValid), .smpReady(smpReady), .smpPoint(smpPoint),
        .smpData(smpData), .sweepRun(sweepRun), .singleSweep(singleSweep), .sweepRearm(sweepRearm),
        .sweepStop(sweepStop), .dispReq(dispReq), .dispPoint(dispPoint), .dispValid(dispValid),
        .dispReady(dispReady), .dispA(dispA), .dispB(dispB), .dispShowA(dispShowA), .dispShowB(dispShowB),
        .dispDiffMid(dispDiffMid), .dispSweepMark(sMk), .dispOffsMark(oMk), .dispTuneMark(tMk),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    dtm_disp_model u_disp (.clk(clk), .nrst(nrst), .pt(pt), .dispReq(dispReq), .dispPoint(dispPoint),
        .dispValid(dispValid), .dispReady(dispReady), .dispA(dispA), .dispB(dispB), .marks({sMk, oMk, tMk}),
        .gotA(gotA), .gotB(gotB), .gotMk(gotMk));
    // clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // sweep pulse counters
    always @(posedge clk) begin
        if (sweepRearm === 1'b1) rearmCnt++;
        if (sweepStop === 1'b1) stopCnt++;
    end
    task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", s, exp, got);
        end
    endtask
    // waits have no limit of their own: the watchdog ends a hang
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // one sample through the handshake
    task automatic smp(input logic [9:0] p, input logic [9:0] d);
        @(posedge clk);
        smpValid <= 1'b1;
        smpPoint <= p;
        smpData <= d;
        do begin
            @(posedge clk);
        end while (smpReady !== 1'b1);
        smpValid <= 1'b0;
    endtask
    task automatic rdpt(input logic [9:0] p, input logic [9:0] a, input logic [9:0] b);
        wr(DTM_REG_RDADDR, {22'h0, p});
        rd(DTM_REG_RDDATA);
        chk("point words", v, {12'h0, a, b});
    endtask
    task automatic idle();
        do begin
            rd(DTM_REG_STAT);
        end while (v[1] !== 1'b0);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #1000000;
        num_errors++;
        results();
    end
    // main sequence
    initial begin
        {nrst, smpValid, sweepRun, singleSweep, awvalid, wvalid, bready, arvalid, rready} = '0;
        {smpPoint, smpData, pt, awaddr, araddr, wdata} = '0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd(DTM_REG_CTRL);
        chk("ctrl reset", v, 32'h81);
        chk("show a", dispShowA, 1);
        // known trace contents: clear A, copy it into B, hide B again
        wr(DTM_REG_CMD, 32'h1);
        idle();
        wr(DTM_REG_CMD, 32'h2);
        idle();
        rdpt(1000, 0, 0);
        wr(DTM_REG_CMD, 32'h4);
        chk("b hidden", dispShowB, 0);
        sweepRun <= 1'b1;
        smp(0, 10'h120);
        smp(500, 10'h300);
        smp(1000, 10'h3ff);
        smp(1001, 10'h001);
        rdpt(0, 10'h120, 0);
        rdpt(1000, 10'h3ff, 0);
        wr(DTM_REG_CMD, 32'h10);
        smp(0, 10'h050);
        rdpt(0, 10'h120, 0);
        smp(0, 10'h140);
        rdpt(0, 10'h140, 0);
        wr(DTM_REG_CMD, 32'h10);
        wr(DTM_REG_CMD, 32'h2);
        wr(DTM_REG_CMD, 32'h1);
        chk("busy refusal", r, DTM_RESP_SLVERR);
        idle();
        rdpt(500, 10'h300, 10'h300);
        chk("show b", dispShowB, 1);
        wr(DTM_REG_CMD, 32'h4);
        rd(DTM_REG_CTRL);
        chk("b toggled off", v[1], 0);
        rdpt(500, 10'h300, 10'h300);
        smp(0, 10'h170);
        smp(500, 10'h100);
        wr(DTM_REG_CMD, 32'h8);
        idle();
        rdpt(0, 10'h030, 10'h140);
        rdpt(500, 0, 10'h300);
        chk("diff mid", dispDiffMid, 1);
        singleSweep <= 1'b1;
        wr(DTM_REG_CMD, 32'h1);
        idle();
        rdpt(1000, 0, 10'h3ff);
        chk("rearm", rearmCnt, 2);
        chk("stop", stopCnt, 1);
        rd(8'h1c);
        chk("bad read", r, DTM_RESP_SLVERR);
        wr(8'h1c, 0);
        chk("bad write", r, DTM_RESP_SLVERR);
        wr(DTM_REG_CTRL, 32'hf1);
        wr(DTM_REG_OFFPT, 32'h1f4);
        wr(DTM_REG_MANPT, 32'h12c);
        smp(700, 10'h2aa);
        // each point in turn at the display port
        for (i = 0; i < 3; i++) begin
            pt <= tp[i];
            repeat (24) @(posedge clk);
            chk("markers", gotMk, mk[i]);
            chk("display words", {gotA, gotB}, ab[i]);
        end
        results();
    end
endmodule // tb
